// File: bench/dac_dec_asserts.sv
// Port checker for the dual channel frame decoder.
`include "dual_dac_defines.vh"
module dac_dec_asserts (
    input wire        sys_clk_i, rst_n_i, frame_sel_n_i, load_strobe_n_i,
    input wire        power_on_code_select_i, span_select_i, serial_clk_i,
    input wire        serial_data_out_o, gain_two_o,
    input wire [15:0] code_a_o, code_b_o,
    input wire [1:0]  pd_a_o, pd_b_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);
    logic seen_q;
    // Set by the first frame; until then the reset code must show.
    always @(posedge sys_clk_i or negedge rst_n_i)
        if (!rst_n_i) seen_q <= 1'b0;
        else if (!frame_sel_n_i) seen_q <= 1'b1;
    sequence s_busy;
        (!frame_sel_n_i && load_strobe_n_i && $stable(power_on_code_select_i)) [*6];
    endsequence
    sequence s_idle;
        (frame_sel_n_i && load_strobe_n_i && $stable(power_on_code_select_i)) [*8];
    endsequence
    AST_RST_OUT: assert property (disable iff (1'b0) !rst_n_i |->
        code_a_o == 0 && code_b_o == 0 && gain_two_o == 0) else $error("reset outputs");
    AST_POR_CODE: assert property ((!seen_q && $stable(power_on_code_select_i)) [*5]
        |-> code_a_o == (power_on_code_select_i ? `CODE_MID : `CODE_ZERO)) else $error("por");
    AST_GAIN: assert property ($stable(span_select_i) [*5]
        |-> gain_two_o == span_select_i) else $error("gain");
    AST_FRAME_HOLD: assert property (s_busy
        |-> $stable(code_a_o) && $stable(code_b_o)) else $error("code moved in frame");
    AST_IDLE_HOLD: assert property (s_idle
        |=> $stable(code_a_o) && $stable(code_b_o)) else $error("code moved idle");
    AST_SDO_QUIET: assert property (($stable(serial_clk_i) && $stable(frame_sel_n_i)) [*8]
        |=> $stable(serial_data_out_o)) else $error("sdo moved");
    AST_PD_A: assert property ($changed(pd_a_o) |-> $stable(code_a_o)) else $error("pd a");
    AST_PD_B: assert property ($changed(pd_b_o) |-> $stable(code_b_o)) else $error("pd b");
endmodule // dac_dec_asserts
bind dual_dac_frame_decoder dac_dec_asserts i_dac_dec_asserts (.*);

// File: bench/dual_dac_serial_frame_decoder_test.sv
// Self-checking bench for the frame decoder.
module dual_dac_serial_frame_decoder_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, rst_n = 1'b0, load_strobe_n_n = 1'b1, posel = 1'b1, span = 1'b0;
    logic sel_n, sclk, sdi, serial_data_out, gain, chain;
    logic [15:0] code_a, code_b;
    logic [1:0] pd_a, pd_b;
    logic [23:0] rx_q = 24'h00_0000;
    int failures = 0, tests_run = 0;
    always #5 clk = ~clk;
    always @(negedge sclk) if (!sel_n) rx_q <= {rx_q[22:0], serial_data_out};
    dual_dac_frame_decoder #(.RES_16(1)) i_dual_dac_frame_decoder (.sys_clk_i(clk),
        .rst_n_i(rst_n), .ce_i(1'b1), .frame_sel_n_i(sel_n), .serial_clk_i(sclk),
        .serial_data_in_i(sdi), .load_strobe_n_i(load_strobe_n_n), .power_on_code_select_i(posel),
        .span_select_i(span), .serial_data_out_o(serial_data_out), .code_a_o(code_a), .code_b_o(code_b),
        .gain_two_o(gain), .pd_a_o(pd_a), .pd_b_o(pd_b), .chain_en_o(chain));
    host_serial_model i_host_serial_model (.sys_clk_i(clk), .frame_sel_n_o(sel_n),
        .serial_clk_o(sclk), .serial_data_o(sdi));
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        @(negedge clk);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
        @(posedge clk);
    endtask
    task automatic conclude();
        if (failures == 0 && tests_run > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic tx(input logic [23:0] f);
        i_host_serial_model.send(f);
    endtask
    initial begin
        #100us;
        failures++;
        conclude();
    end
    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        repeat (10) @(posedge clk);
        check("por", {code_b, code_a}, 32'h8000_8000);
        tx({4'h3, 4'hC, 16'hFFFF});
        check("wr_upd", {code_b, code_a}, 32'hFFFF_FFFF);
        posel <= 1'b0;
        tx({4'h1, 4'h4, 16'h1234});
        i_host_serial_model.noise();
        check("wr_in", {code_b, code_a}, 32'hFFFF_FFFF);
        tx({4'h2, 4'h4, 16'h0000});
        check("upd", {code_b, code_a}, 32'hFFFF_1234);
        tx({4'h1, 4'h8, 16'h00A5});
        load_strobe_n_n <= 1'b0;
        repeat (8) @(posedge clk);
        load_strobe_n_n <= 1'b1;
        repeat (8) @(posedge clk);
        check("load_strobe_n", {code_b, code_a}, 32'h00A5_1234);
        tx({4'h4, 4'h0, 16'h0042});
        check("pd", {12'h000, pd_b, pd_a, code_a}, 32'h0006_1234);
        tx({4'h9, 4'h4, 16'h0000});
        tx(24'h00_0000);
        check("readback", {8'h00, rx_q}, 32'h0001_2340);
        tx({4'h8, 4'h0, 16'h0001});
        check("chain", {31'h0, chain}, 32'h0000_0001);
        span <= 1'b1;
        repeat (8) @(posedge clk);
        check("gain", {31'h0, gain}, 32'h0000_0001);
        rst_n <= 1'b0;
        repeat (12) @(posedge clk);
        check("rst_out", {14'h0000, chain, gain, code_a}, 32'h0000_0000);
        rst_n <= 1'b1;
        repeat (10) @(posedge clk);
        check("por_zero", {code_b, code_a}, 32'h0000_0000);
        conclude();
    end
endmodule // dual_dac_serial_frame_decoder_test

// File: bench/host_serial_model.sv
// Host side serial controller model.
module host_serial_model (
    input  wire logic sys_clk_i,
    output logic      frame_sel_n_o,
    output logic      serial_clk_o,
    output logic      serial_data_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        frame_sel_n_o = 1'b1;
        serial_clk_o = 1'b1;
        serial_data_o = 1'b0;
    end
    task automatic phase(input logic level);
        repeat (8) @(posedge sys_clk_i);
        serial_clk_o <= level;
    endtask
    task automatic send(input logic [23:0] frame);
        @(posedge sys_clk_i) frame_sel_n_o <= 1'b0;
        for (int i = 23; i >= 0; i--) begin
            serial_data_o <= frame[i];
            phase(1'b0);
            phase(1'b1);
        end
        phase(1'b1);
        frame_sel_n_o <= 1'b1;
        serial_data_o <= ~serial_data_o;
        repeat (12) @(posedge sys_clk_i);
    endtask
    task automatic noise();
        repeat (4) begin
            phase(~serial_clk_o);
            serial_data_o <= ~serial_data_o;
        end
    endtask
endmodule // host_serial_model

// File: rtl/dual_dac_defines.vh
// Constants for the dual-channel converter serial front end.
`ifndef DUAL_DAC_DEFINES_VH
`define DUAL_DAC_DEFINES_VH
`define FRAME_BITS        24
`define FRAME_CNT_W       5
`define FRAME_COUNT_FULL  5'h18
`define CMD_MSB_POS       23
`define CMD_LSB_POS       20
`define ADDR_B_POS        19
`define ADDR_A_POS        18
`define DATA_MSB_POS      15
`define CODE_W            16
`define CMD_NOP           4'h0
`define CMD_WRITE_INPUT   4'h1
`define CMD_UPDATE_DAC    4'h2
`define CMD_WRITE_UPDATE  4'h3
`define CMD_POWER_DOWN    4'h4
`define CMD_CHAIN_ENABLE  4'h8
`define CMD_READBACK      4'h9
`define CODE_ZERO         16'h0000
`define CODE_MID          16'h8000
`define PD_FIELD_W        2
`endif

// File: rtl/dual_dac_frame_decoder.v
// Serial frame decoder and channel register file of a dual-channel converter.
// Summary of operation
// - Each write is one 24-bit frame over frame select, serial clock and serial data in.
// - Bits arrive most significant first and shift into a 24-bit register in arrival order.
// - Frame bits 23 to 20 form the command, first bit as its most significant bit.
// - Bits 19 to 16 are channel B select, channel A select and two unused zero bits.
// - The bits below the address field are the data word of the command.
// - Channel codes are unsigned straight binary of 12 or 16 bits.
// - The span pin sets gain one when low and gain two when high, for both channels.
// - Reset forces both channels to a known code before any frame arrives.
// - A serial data output carries chained frames or readback contents.
// - A power-down state is entered by a serial command.
// - Bits are sampled on falling serial clock edges and act on the rising frame select edge.
// - 16-bit codes fill the low 16 bits; 12-bit codes are followed by four ignored bits.
// - Command 1 writes input registers, 2 copies them to channels, 3 writes channels directly.
// - The reset code is zero or midscale from a select pin and holds until a write.
`include "dual_dac_defines.vh"
module dual_dac_frame_decoder #(
    parameter RES_16 = 1
) (
    input  wire        sys_clk_i,
    input  wire        rst_n_i,
    input  wire        ce_i,
    input  wire        frame_sel_n_i,
    input  wire        serial_clk_i,
    input  wire        serial_data_in_i,
    input  wire        load_strobe_n_i,
    input  wire        power_on_code_select_i,
    input  wire        span_select_i,
    output reg         serial_data_out_o,
    output reg  [15:0] code_a_o,
    output reg  [15:0] code_b_o,
    output reg         gain_two_o,
    output reg  [1:0]  pd_a_o,
    output reg  [1:0]  pd_b_o,
    output reg         chain_en_o
);
    // ------------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------------
    wire sel_n_s;
    wire sclk_s;
    wire serial_data_in_s;
    wire load_strobe_n_n_s;
    wire power_on_code_select_s;
    wire span_s;
    wire [5:0] raw_in = {frame_sel_n_i, serial_clk_i, serial_data_in_i,
                         load_strobe_n_i, power_on_code_select_i, span_select_i};
    wire [5:0] syn_out;
    genvar g;
    generate
        for (g = 0; g < 6; g = g + 1) begin : g_sync
            // Each pin passes two flip-flops before any logic reads it.
            // Select, serial clock and load strobe idle high, so their
            // synchronisers reset high and no false edge follows reset.
            sync_2ff #(.RESET_VAL((g == 5 || g == 4 || g == 2) ? 1'b1 : 1'b0)) u_sync (
                .sys_clk_i (sys_clk_i),
                .rst_n_i   (rst_n_i),
                .ce_i      (ce_i),
                .async_i   (raw_in[g]),
                .sync_o    (syn_out[g])
            );
        end
    endgenerate
    assign {sel_n_s, sclk_s, serial_data_in_s, load_strobe_n_n_s, power_on_code_select_s, span_s} = syn_out;

    // Aligns a 16-bit or 12-bit code from the data field.
    function [15:0] data_code;
        input [23:0] f;
        begin
            if (RES_16 != 0)
                data_code = f[`DATA_MSB_POS:0];
            else
                data_code = {4'h0, f[`DATA_MSB_POS:4]};
        end
    endfunction

    // ------------------------------------------------------------------
    // Edge detection and shifting
    // ------------------------------------------------------------------
    reg         sclk_q;
    reg         sel_n_q;
    reg  [23:0] shift_q;
    reg  [4:0]  bit_cnt_q;
    reg         first_q;
    reg  [15:0] in_a_q;
    reg  [15:0] in_b_q;
    reg  [15:0] rb_q;
    wire        sclk_fall = sclk_q & ~sclk_s;
    wire        sclk_rise = ~sclk_q & sclk_s;
    wire        sel_rise  = ~sel_n_q & sel_n_s;
    wire        sel_fall  = sel_n_q & ~sel_n_s;
    wire [3:0]  cmd       = shift_q[`CMD_MSB_POS:`CMD_LSB_POS];
    wire        sel_b     = shift_q[`ADDR_B_POS];
    wire        sel_a     = shift_q[`ADDR_A_POS];
    wire [15:0] word      = data_code(shift_q);
    wire [15:0] por_code  = power_on_code_select_s ? `CODE_MID : `CODE_ZERO;
    // Readback reads channel B only when B alone is selected; any other
    // address reads channel A.
    wire        rb_b      = sel_b & ~sel_a;

    // ------------------------------------------------------------------
    // Span select
    // ------------------------------------------------------------------
    // The span pin is static in use, so its synchronised level is simply
    // registered; both channels share the one gain output.
    always @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            gain_two_o <= 1'b0;
        end else if (ce_i) begin
            gain_two_o <= span_s;
        end
    end

    // ------------------------------------------------------------------
    // Serial data out
    // ------------------------------------------------------------------
    // The output moves after each detected rising serial clock edge while select is low, so that
    // it is settled well before the host samples it on the next fall.
    // At the start of a frame the freshly loaded top bit, always zero, is
    // shown at once: no rising edge precedes the first fall, and without
    // this the host would read the previous frame's last bit first.
    always @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            serial_data_out_o <= 1'b0;
        end else if (ce_i) begin
            if (sel_fall) begin
                serial_data_out_o <= 1'b0;
            end else if (!sel_n_s && sclk_rise) begin
                serial_data_out_o <= shift_q[23];
            end
        end
    end

    // ------------------------------------------------------------------
    // Frame capture and command execution
    // ------------------------------------------------------------------
    // The bit counter saturates at a full frame; a longer burst keeps the
    // last 24 bits and the surplus leaves on the serial data output.
    // A frame with no bits at all is refused when select rises, so a bare
    // select pulse cannot replay the command left in the shift register.
    // Shorter frames act on whatever the shift register then holds.
    // Power-down fields never touch the channel codes or input registers.

    always @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sclk_q            <= 1'b1;
            sel_n_q           <= 1'b1;
            shift_q           <= 24'h00_0000;
            bit_cnt_q         <= 5'h00;
            first_q           <= 1'b1;
            code_a_o          <= `CODE_ZERO;
            code_b_o          <= `CODE_ZERO;
            in_a_q            <= `CODE_ZERO;
            in_b_q            <= `CODE_ZERO;
            rb_q              <= 16'h0000;
            pd_a_o            <= 2'h0;
            pd_b_o            <= 2'h0;
            chain_en_o        <= 1'b0;
        end else if (ce_i) begin
            sclk_q     <= sclk_s;
            sel_n_q    <= sel_n_s;
            // Until a write frame (command 1, 2 or 3) has acted, follow the reset-code select pin.
            if (first_q) begin
                code_a_o <= por_code;
                code_b_o <= por_code;
                in_a_q   <= por_code;
                in_b_q   <= por_code;
            end
            if (sel_fall) begin
                bit_cnt_q <= 5'h00;
                // Readback data leads the next frame.
                shift_q   <= {4'h0, rb_q, 4'h0};
            end else if (!sel_n_s && sclk_fall) begin
                shift_q   <= {shift_q[22:0], serial_data_in_s};
                if (bit_cnt_q != `FRAME_COUNT_FULL)
                    bit_cnt_q <= bit_cnt_q + 5'h01;
            end
            if (sel_rise && bit_cnt_q != 5'h00) begin
                case (cmd)
                    `CMD_WRITE_INPUT: begin
                        first_q <= 1'b0;
                        if (sel_a) in_a_q <= word;
                        if (sel_b) in_b_q <= word;
                        if (!load_strobe_n_n_s && sel_a) code_a_o <= word;
                        if (!load_strobe_n_n_s && sel_b) code_b_o <= word;
                    end
                    `CMD_UPDATE_DAC: begin
                        first_q <= 1'b0;
                        if (sel_a) code_a_o <= in_a_q;
                        if (sel_b) code_b_o <= in_b_q;
                    end
                    `CMD_WRITE_UPDATE: begin
                        first_q <= 1'b0;
                        if (sel_a) begin
                            code_a_o <= word;
                            in_a_q   <= word;
                        end
                        if (sel_b) begin
                            code_b_o <= word;
                            in_b_q   <= word;
                        end
                    end
                    `CMD_POWER_DOWN: begin
                        pd_a_o <= shift_q[1:0];
                        pd_b_o <= shift_q[7:6];
                    end
                    `CMD_CHAIN_ENABLE: chain_en_o <= shift_q[0];
                    `CMD_READBACK:     rb_q <= rb_b ? code_b_o : code_a_o;
                    default: ;
                endcase
            end else if (sel_n_s && !load_strobe_n_n_s && !first_q) begin
                // A low load strobe between frames copies both input registers.
                code_a_o <= in_a_q;
                code_b_o <= in_b_q;
            end
        end
    end
endmodule // dual_dac_frame_decoder

// File: rtl/sync_2ff.v
// Two-flip-flop level synchroniser for a single bit.
module sync_2ff #(
    parameter RESET_VAL = 1'b0
) (
    input  wire sys_clk_i,
    input  wire rst_n_i,
    input  wire ce_i,
    input  wire async_i,
    output reg  sync_o
);
    reg meta_q;
    always @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta_q <= RESET_VAL;
            sync_o <= RESET_VAL;
        end else if (ce_i) begin
            meta_q <= async_i;
            sync_o <= meta_q;
        end
    end
endmodule // sync_2ff
